// ### omc_core_model.sv
`timescale 1ns/1ns
// Core side: latches hold until cleared; time base sources run free.
module omc_core_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [7:0] raise_in,
    input wire logic clear_in,
    output logic [7:0] irq_latch_out,
    output logic [7:0] tb_src_out
);
    logic [8:0] div_q;
    // Slow sources keep a deep doze long enough to be read back.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            div_q <= 9'h000;
            irq_latch_out <= 8'h00;
        end else begin
            div_q <= div_q + 9'h001;
            irq_latch_out <= clear_in ? 8'h00 : irq_latch_out | raise_in;
        end
    end
    assign tb_src_out = div_q[8:1];
endmodule

// ### omc_operation_mode_controller.sv
`timescale 1ns/1ns
// Behaviour
// - Reset release enters single_run.
// - Single-clock modes run system from gear clock.
// - Low oscillator pins are GPIO in single-clock while the low oscillator is disabled.
// - Core halt bit enters single_doze.
// - Enabled interrupt latch ends single_doze.
// - Wake services interrupt when master flag set.
// - Timing generator stop bit enters single_deep_doze.
// - Time base source falling edge ends deep doze.
// - Deep doze ignores enable; sets time base latch only when the time base is enabled.
// - Time base service needs master and enable flags.
// - Slow and sleep modes use quarter low clock.
// - dual_fast_run: core on gear clock.
// - Clock select switches dual fast and slow.
// - Slow modes hold prescaler and stages 1-8.
// - High oscillator enable moves slow_only and dual_slow.
// - dual_fast_doze behaves like single_doze.
// - slow_only_doze behaves like single_doze, slow clocks.
// - slow_only_deep_doze behaves like deep doze.
// - Stop bit halts oscillators, keeps state.
// - Stop release waits warm-up, returns prior mode.
// - Warm-up ends when upper eight bits match.
// - Pin, key or voltage release stop; reset too.
// - Software oscillator enable runs warm-up, raises interrupt.
module omc_operation_mode_controller (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic apb_psel_in,
    input wire logic apb_penable_in,
    input wire logic apb_pwrite_in,
    input wire logic [7:0] apb_paddr_in,
    input wire logic [31:0] apb_pwdata_in,
    output logic [31:0] apb_prdata_out,
    output logic apb_pready_out,
    output logic apb_pslverr_out,
    input wire logic [omc_pkg::NUM_IRQ-1:0] irq_latch_in,
    input wire logic interrupt_master_flag_in,
    input wire logic [omc_pkg::NUM_TB_SRC-1:0] tb_src_clk_in,
    input wire logic stop_pin_release_in,
    input wire logic key_wakeup_in,
    input wire logic volt_detect_release_in,
    output logic cpu_clk_en_out,
    output logic wdt_clk_en_out,
    output logic tb_clk_en_out,
    output logic periph_clk_en_out,
    output logic high_osc_run_out,
    output logic low_osc_run_out,
    output logic sys_clk_from_low_out,
    output logic prescaler_run_out,
    output logic low_osc_pins_gpio_out,
    output logic tb_irq_set_out,
    output logic warmup_done_irq_out,
    output logic service_irq_out
);

    omc_pkg::omc_mode_type state_q;
    omc_pkg::omc_mode_type state_d;
    omc_pkg::omc_mode_type saved_mode_q;
    logic high_osc_en_q;
    logic low_osc_en_q;
    logic clk_sel_q;
    logic tb_en_q;
    logic [omc_pkg::TB_SEL_W-1:0] tb_sel_q;
    logic [omc_pkg::NUM_IRQ-1:0] irq_en_q;
    logic [omc_pkg::WARMUP_CMP_W-1:0] warmup_cmp_q;
    logic [omc_pkg::WARMUP_W-1:0] warmup_cnt_q;
    logic warmup_busy_q;
    logic tb_src_prev_q;
    logic tb_armed_q;
    logic halt_req, tg_stop_req, stop_req;
    logic wr_fire, rd_phase, mapped;
    logic [31:0] rd_data;
    logic tb_src_sel, tb_fall, doze_wake, stop_release;
    logic warmup_match, sw_warmup_start;
    logic gate_cpu, gate_wdt, gate_tb, gate_periph;
    logic gate_high, gate_low, gate_slow;

    // One wait state keeps the bus answer in flip-flops; writes land on
    // the completing edge.
    assign rd_phase = apb_psel_in & apb_penable_in & ~apb_pready_out;
    assign wr_fire = apb_psel_in & apb_penable_in & apb_pready_out
        & apb_pwrite_in;

    // Command bits act only when written as one; they read back as zero.
    assign halt_req = wr_fire && apb_paddr_in == omc_pkg::SYSCTL_B_OFS
        && apb_pwdata_in[omc_pkg::CORE_HALT_BIT];
    assign tg_stop_req = wr_fire && apb_paddr_in == omc_pkg::SYSCTL_B_OFS
        && apb_pwdata_in[omc_pkg::TG_STOP_BIT];
    assign stop_req = wr_fire && apb_paddr_in == omc_pkg::SYSCTL_A_OFS
        && apb_pwdata_in[omc_pkg::STOP_REQ_BIT];

    // Read mux and decode; unmapped addresses answer with an error.
    always_comb begin
        mapped = 1'b1;
        rd_data = 32'h0000_0000;
        case (apb_paddr_in)
            omc_pkg::SYSCTL_A_OFS: rd_data = 32'h0000_0000;
            omc_pkg::SYSCTL_B_OFS: begin
                rd_data[omc_pkg::HIGH_OSC_EN_BIT] = high_osc_en_q;
                rd_data[omc_pkg::LOW_OSC_EN_BIT] = low_osc_en_q;
                rd_data[omc_pkg::CLK_SEL_BIT] = clk_sel_q;
            end
            omc_pkg::TB_CTRL_OFS: begin
                rd_data[omc_pkg::TB_EN_BIT] = tb_en_q;
                rd_data[omc_pkg::TB_SEL_LSB +: omc_pkg::TB_SEL_W] = tb_sel_q;
            end
            omc_pkg::IRQ_EN_OFS: rd_data[omc_pkg::NUM_IRQ-1:0] = irq_en_q;
            omc_pkg::WARMUP_CMP_OFS: begin
                rd_data[omc_pkg::WARMUP_CMP_W-1:0] = warmup_cmp_q;
            end
            omc_pkg::STATUS_OFS: begin
                rd_data[omc_pkg::STATE_W-1:0] = state_q;
                rd_data[omc_pkg::STAT_WARMUP_BIT] = warmup_busy_q;
            end
            default: mapped = 1'b0;
        endcase
    end

    // Bus answer registers.
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            apb_pready_out <= 1'b0;
            apb_prdata_out <= 32'h0000_0000;
            apb_pslverr_out <= 1'b0;
        end else begin
            apb_pready_out <= rd_phase;
            apb_pslverr_out <= rd_phase & ~mapped;
            if (rd_phase && !apb_pwrite_in) begin
                apb_prdata_out <= rd_data;
            end
        end
    end

    // Software-visible configuration; the mode machine follows it.
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            high_osc_en_q <= omc_pkg::HIGH_OSC_EN_RST;
            low_osc_en_q <= omc_pkg::LOW_OSC_EN_RST;
            clk_sel_q <= omc_pkg::CLK_SEL_RST;
            tb_en_q <= 1'b0;
            tb_sel_q <= 3'h0;
            irq_en_q <= 8'h00;
            warmup_cmp_q <= omc_pkg::WARMUP_CMP_RST;
        end else if (wr_fire) begin
            case (apb_paddr_in)
                omc_pkg::SYSCTL_B_OFS: begin
                    high_osc_en_q <= apb_pwdata_in[omc_pkg::HIGH_OSC_EN_BIT];
                    low_osc_en_q <= apb_pwdata_in[omc_pkg::LOW_OSC_EN_BIT];
                    clk_sel_q <= apb_pwdata_in[omc_pkg::CLK_SEL_BIT];
                end
                omc_pkg::TB_CTRL_OFS: begin
                    tb_en_q <= apb_pwdata_in[omc_pkg::TB_EN_BIT];
                    tb_sel_q <= apb_pwdata_in[omc_pkg::TB_SEL_LSB +:
                        omc_pkg::TB_SEL_W];
                end
                omc_pkg::IRQ_EN_OFS: begin
                    irq_en_q <= apb_pwdata_in[omc_pkg::NUM_IRQ-1:0];
                end
                omc_pkg::WARMUP_CMP_OFS: begin
                    warmup_cmp_q <= apb_pwdata_in[omc_pkg::WARMUP_CMP_W-1:0];
                end
                default: ;
            endcase
        end
    end

    // Wake and release sources.
    assign tb_src_sel = tb_src_clk_in[tb_sel_q];
    assign tb_fall = tb_armed_q & tb_src_prev_q & ~tb_src_sel;
    assign doze_wake = |(irq_latch_in & irq_en_q);
    assign stop_release = stop_pin_release_in | key_wakeup_in
        | volt_detect_release_in;
    assign warmup_match = warmup_cnt_q[omc_pkg::WARMUP_W-1 -:
        omc_pkg::WARMUP_CMP_W] == warmup_cmp_q;

    // Falling-edge detector, armed only in deep doze so that an edge
    // seen before entry cannot wake it.
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            tb_src_prev_q <= 1'b0;
            tb_armed_q <= 1'b0;
        end else begin
            tb_src_prev_q <= tb_src_sel;
            tb_armed_q <= state_q == omc_pkg::SINGLE_DEEP_DOZE
                || state_q == omc_pkg::SLOW_ONLY_DEEP_DOZE;
        end
    end

    // Software enabling a stopped oscillator starts the warm-up.
    assign sw_warmup_start = wr_fire
        && apb_paddr_in == omc_pkg::SYSCTL_B_OFS
        && ((apb_pwdata_in[omc_pkg::HIGH_OSC_EN_BIT] && !high_osc_en_q)
        || (apb_pwdata_in[omc_pkg::LOW_OSC_EN_BIT] && !low_osc_en_q));

    // Warm-up counter, shared by software enables and stop release.
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            warmup_cnt_q <= 14'h0000;
            warmup_busy_q <= 1'b0;
            warmup_done_irq_out <= 1'b0;
        end else begin
            warmup_done_irq_out <= 1'b0;
            if (warmup_busy_q && warmup_match) begin
                warmup_busy_q <= 1'b0;
                warmup_cnt_q <= 14'h0000;
                warmup_done_irq_out <= state_q != omc_pkg::STOP_WARMUP;
            end else if (warmup_busy_q
                    && state_q != omc_pkg::STOP_HOLD) begin
                warmup_cnt_q <= warmup_cnt_q + 14'h0001;
            end else if (sw_warmup_start
                    || (state_q == omc_pkg::STOP_HOLD && stop_release)) begin
                warmup_busy_q <= 1'b1;
                warmup_cnt_q <= 14'h0000;
            end
        end
    end

    // Mode transitions.
    always_comb begin
        state_d = state_q;
        case (state_q)
            omc_pkg::SINGLE_RUN: begin
                if (stop_req) begin
                    state_d = omc_pkg::STOP_HOLD;
                end else if (halt_req) begin
                    state_d = omc_pkg::SINGLE_DOZE;
                end else if (tg_stop_req) begin
                    state_d = omc_pkg::SINGLE_DEEP_DOZE;
                end else if (low_osc_en_q && !warmup_busy_q) begin
                    state_d = omc_pkg::DUAL_FAST_RUN;
                end
            end
            omc_pkg::SINGLE_DOZE: begin
                if (doze_wake) begin
                    state_d = omc_pkg::SINGLE_RUN;
                end
            end
            omc_pkg::SINGLE_DEEP_DOZE: begin
                if (tb_fall) begin
                    state_d = omc_pkg::SINGLE_RUN;
                end
            end
            omc_pkg::DUAL_FAST_RUN: begin
                if (stop_req) begin
                    state_d = omc_pkg::STOP_HOLD;
                end else if (halt_req) begin
                    state_d = omc_pkg::DUAL_FAST_DOZE;
                end else if (!low_osc_en_q) begin
                    state_d = omc_pkg::SINGLE_RUN;
                end else if (clk_sel_q) begin
                    state_d = omc_pkg::DUAL_SLOW_RUN;
                end
            end
            omc_pkg::DUAL_FAST_DOZE: begin
                if (doze_wake) begin
                    state_d = omc_pkg::DUAL_FAST_RUN;
                end
            end
            omc_pkg::DUAL_SLOW_RUN: begin
                if (stop_req) begin
                    state_d = omc_pkg::STOP_HOLD;
                end else if (!high_osc_en_q) begin
                    state_d = omc_pkg::SLOW_ONLY_RUN;
                end else if (!clk_sel_q) begin
                    state_d = omc_pkg::DUAL_FAST_RUN;
                end
            end
            omc_pkg::SLOW_ONLY_RUN: begin
                if (stop_req) begin
                    state_d = omc_pkg::STOP_HOLD;
                end else if (halt_req) begin
                    state_d = omc_pkg::SLOW_ONLY_DOZE;
                end else if (tg_stop_req) begin
                    state_d = omc_pkg::SLOW_ONLY_DEEP_DOZE;
                end else if (high_osc_en_q && !warmup_busy_q) begin
                    state_d = omc_pkg::DUAL_SLOW_RUN;
                end
            end
            omc_pkg::SLOW_ONLY_DOZE: begin
                if (doze_wake) begin
                    state_d = omc_pkg::SLOW_ONLY_RUN;
                end
            end
            omc_pkg::SLOW_ONLY_DEEP_DOZE: begin
                if (tb_fall) begin
                    state_d = omc_pkg::SLOW_ONLY_RUN;
                end
            end
            omc_pkg::STOP_HOLD: begin
                if (stop_release) begin
                    state_d = omc_pkg::STOP_WARMUP;
                end
            end
            omc_pkg::STOP_WARMUP: begin
                if (warmup_match) begin
                    state_d = saved_mode_q;
                end
            end
            default: state_d = omc_pkg::SINGLE_RUN;
        endcase
    end

    // Mode register; the mode at stop entry is kept for the return.
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            state_q <= omc_pkg::SINGLE_RUN;
            saved_mode_q <= omc_pkg::SINGLE_RUN;
        end else begin
            state_q <= state_d;
            if (state_d == omc_pkg::STOP_HOLD
                    && state_q != omc_pkg::STOP_HOLD) begin
                saved_mode_q <= state_q;
            end
        end
    end

    // Clock gates per consumer, decoded from the next mode so that the
    // registered outputs line up with the mode register.
    always_comb begin
        gate_cpu = 1'b0;
        gate_wdt = 1'b0;
        gate_tb = 1'b1;
        gate_periph = 1'b1;
        gate_high = 1'b1;
        gate_low = low_osc_en_q;
        gate_slow = 1'b0;
        case (state_d)
            omc_pkg::SINGLE_RUN, omc_pkg::DUAL_FAST_RUN: begin
                gate_cpu = 1'b1;
                gate_wdt = 1'b1;
            end
            omc_pkg::SINGLE_DOZE, omc_pkg::DUAL_FAST_DOZE: begin
                gate_cpu = 1'b0;
            end
            omc_pkg::SINGLE_DEEP_DOZE: begin
                gate_periph = 1'b0;
            end
            omc_pkg::DUAL_SLOW_RUN: begin
                gate_cpu = 1'b1;
                gate_wdt = 1'b1;
                gate_slow = 1'b1;
            end
            omc_pkg::SLOW_ONLY_RUN: begin
                gate_cpu = 1'b1;
                gate_wdt = 1'b1;
                gate_high = 1'b0;
                gate_slow = 1'b1;
            end
            omc_pkg::SLOW_ONLY_DOZE: begin
                gate_high = 1'b0;
                gate_slow = 1'b1;
            end
            omc_pkg::SLOW_ONLY_DEEP_DOZE: begin
                gate_high = 1'b0;
                gate_periph = 1'b0;
                gate_slow = 1'b1;
            end
            omc_pkg::STOP_HOLD: begin
                gate_tb = 1'b0;
                gate_periph = 1'b0;
                gate_high = 1'b0;
                gate_low = 1'b0;
            end
            omc_pkg::STOP_WARMUP: begin
                gate_tb = 1'b0;
                gate_periph = 1'b0;
                gate_high = saved_mode_q != omc_pkg::SLOW_ONLY_RUN;
                gate_slow = saved_mode_q == omc_pkg::SLOW_ONLY_RUN;
            end
            default: ;
        endcase
    end

    // Registered gate outputs.
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            cpu_clk_en_out <= 1'b0;
            wdt_clk_en_out <= 1'b0;
            tb_clk_en_out <= 1'b0;
            periph_clk_en_out <= 1'b0;
            high_osc_run_out <= 1'b1;
            low_osc_run_out <= 1'b0;
            sys_clk_from_low_out <= 1'b0;
            prescaler_run_out <= 1'b0;
            low_osc_pins_gpio_out <= 1'b1;
        end else begin
            cpu_clk_en_out <= gate_cpu;
            wdt_clk_en_out <= gate_wdt;
            tb_clk_en_out <= gate_tb;
            periph_clk_en_out <= gate_periph;
            high_osc_run_out <= gate_high;
            low_osc_run_out <= gate_low;
            sys_clk_from_low_out <= gate_slow;
            prescaler_run_out <= ~gate_slow & gate_periph;
            // The oscillator pins stay ports while the low oscillator is not running.
            low_osc_pins_gpio_out <= ~gate_low;
        end
    end

    // Wake notices; the core services or resumes as these pulses say.
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            tb_irq_set_out <= 1'b0;
            service_irq_out <= 1'b0;
        end else begin
            tb_irq_set_out <= 1'b0;
            service_irq_out <= 1'b0;
            if (tb_fall) begin
                tb_irq_set_out <= tb_en_q;
                service_irq_out <= tb_en_q & interrupt_master_flag_in
                    & irq_en_q[omc_pkg::TB_IRQ_EN_IDX];
            end else if (doze_wake && (state_q == omc_pkg::SINGLE_DOZE
                    || state_q == omc_pkg::DUAL_FAST_DOZE
                    || state_q == omc_pkg::SLOW_ONLY_DOZE)) begin
                service_irq_out <= interrupt_master_flag_in;
            end
        end
    end

endmodule

// ### omc_operation_mode_controller_bench.sv
`timescale 1ns/1ns
module omc_operation_mode_controller_bench;
    logic ref_clk_in = 1'b0, sys_rst_in = 1'b1;
    logic apb_psel_in = 1'b0, apb_penable_in = 1'b0, apb_pwrite_in = 1'b0;
    logic [7:0] apb_paddr_in = 8'h00;
    logic [31:0] apb_pwdata_in = 32'h0, apb_prdata_out, rd;
    logic apb_pready_out, apb_pslverr_out, err;
    logic [7:0] irq_latch_in, tb_src_clk_in, raise = 8'h00;
    logic interrupt_master_flag_in = 1'b0, clr = 1'b0;
    logic stop_pin_release_in = 1'b0, key_wakeup_in = 1'b0;
    logic volt_detect_release_in = 1'b0;
    logic cpu_clk_en_out, wdt_clk_en_out, tb_clk_en_out, periph_clk_en_out;
    logic high_osc_run_out, low_osc_run_out, sys_clk_from_low_out;
    logic prescaler_run_out, low_osc_pins_gpio_out;
    logic tb_irq_set_out, warmup_done_irq_out, service_irq_out;
    logic [8:0] gates;
    int failures = 0, comparisons = 0, n_tb = 0, n_wu = 0, n_svc = 0, k, m;

    omc_operation_mode_controller DUT (.*);
    omc_core_model FAR (.clk_in(ref_clk_in), .rst_in(sys_rst_in),
        .raise_in(raise), .clear_in(clr), .irq_latch_out(irq_latch_in),
        .tb_src_out(tb_src_clk_in));

    always #50 ref_clk_in = ~ref_clk_in;
    assign gates = {cpu_clk_en_out, wdt_clk_en_out, tb_clk_en_out,
        periph_clk_en_out, high_osc_run_out, low_osc_run_out,
        sys_clk_from_low_out, prescaler_run_out, low_osc_pins_gpio_out};
    // Pulses last one cycle, so they are counted rather than polled.
    always @(posedge ref_clk_in) begin
        n_tb += (tb_irq_set_out === 1'b1);
        n_wu += (warmup_done_irq_out === 1'b1);
        n_svc += (service_irq_out === 1'b1);
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task test_done;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // One APB transfer; the request stands until pready is sampled high.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk_in);
        apb_psel_in <= 1'b1;
        apb_pwrite_in <= wr;
        apb_paddr_in <= a;
        apb_pwdata_in <= d;
        @(posedge ref_clk_in);
        apb_penable_in <= 1'b1;
        do @(posedge ref_clk_in); while (apb_pready_out !== 1'b1);
        rd = apb_prdata_out;
        err = apb_pslverr_out;
        apb_psel_in <= 1'b0;
        apb_penable_in <= 1'b0;
    endtask

    // Polls the status mode until it matches, then judges the gates.
    task automatic reach(input omc_pkg::omc_mode_type m, input logic [8:0] g,
                         input logic [8:0] mk);
        int i;
        i = 0;
        do begin
            apb(1'b0, omc_pkg::STATUS_OFS, 32'h0);
            i++;
        end while (rd[10:0] !== m && i < 300);
        check({21'h0, rd[10:0]}, {21'h0, m});
        check({23'h0, gates & mk}, {23'h0, g & mk});
    endtask

    task automatic pulse(input logic [7:0] r, input logic c);
        @(posedge ref_clk_in);
        raise <= r;
        clr <= c;
        @(posedge ref_clk_in);
        raise <= 8'h00;
        clr <= 1'b0;
    endtask

    task t_reset;
        reach(omc_pkg::SINGLE_RUN, 9'h1f3, 9'h1ff);
        apb(1'b0, omc_pkg::SYSCTL_B_OFS, 32'h0);
        check(rd, 32'h80);
        apb(1'b0, omc_pkg::WARMUP_CMP_OFS, 32'h0);
        check(rd, 32'h66);
        apb(1'b1, 8'h18, 32'hff);
        check({31'h0, err}, 32'h1);
        apb(1'b0, 8'h18, 32'h0);
        check({rd[30:0], err}, 32'h1);
    endtask

    task t_doze;
        interrupt_master_flag_in <= 1'b1;
        apb(1'b1, omc_pkg::IRQ_EN_OFS, 32'h01);
        apb(1'b1, omc_pkg::SYSCTL_B_OFS, 32'h88);
        reach(omc_pkg::SINGLE_DOZE, 9'h073, 9'h1ff);
        pulse(8'h02, 1'b0);
        repeat (8) @(posedge ref_clk_in);
        reach(omc_pkg::SINGLE_DOZE, 9'h073, 9'h1ff);
        k = n_svc;
        pulse(8'h01, 1'b0);
        reach(omc_pkg::SINGLE_RUN, 9'h1f3, 9'h1ff);
        check(n_svc - k, 1);
        pulse(8'h00, 1'b1);
    endtask

    // Second entry has the time base disabled: no latch, no service.
    task t_deep;
        apb(1'b1, omc_pkg::IRQ_EN_OFS, 32'h20);
        for (int j = 0; j < 2; j++) begin
            apb(1'b1, omc_pkg::TB_CTRL_OFS, j ? 32'h07 : 32'h87);
            k = n_tb;
            m = n_svc;
            apb(1'b1, omc_pkg::SYSCTL_B_OFS, 32'h84);
            reach(omc_pkg::SINGLE_DEEP_DOZE, 9'h040, 9'h1e0);
            reach(omc_pkg::SINGLE_RUN, 9'h1f3, 9'h1ff);
            check(n_tb - k, 1 - j);
            check(n_svc - m, 1 - j);
        end
    endtask

    task t_dual;
        apb(1'b1, omc_pkg::WARMUP_CMP_OFS, 32'h01);
        k = n_wu;
        apb(1'b1, omc_pkg::SYSCTL_B_OFS, 32'hc0);
        reach(omc_pkg::DUAL_FAST_RUN, 9'h1fa, 9'h1ff);
        check(n_wu - k, 1);
        apb(1'b1, omc_pkg::SYSCTL_B_OFS, 32'he0);
        reach(omc_pkg::DUAL_SLOW_RUN, 9'h1fc, 9'h1ff);
        apb(1'b1, omc_pkg::SYSCTL_B_OFS, 32'h60);
        reach(omc_pkg::SLOW_ONLY_RUN, 9'h1ec, 9'h1ff);
        interrupt_master_flag_in <= 1'b0;
        apb(1'b1, omc_pkg::IRQ_EN_OFS, 32'h01);
        apb(1'b1, omc_pkg::SYSCTL_B_OFS, 32'h68);
        reach(omc_pkg::SLOW_ONLY_DOZE, 9'h06c, 9'h1ff);
        k = n_svc;
        pulse(8'h01, 1'b0);
        reach(omc_pkg::SLOW_ONLY_RUN, 9'h1ec, 9'h1ff);
        check(n_svc, k);
        pulse(8'h00, 1'b1);
        apb(1'b1, omc_pkg::SYSCTL_B_OFS, 32'h64);
        reach(omc_pkg::SLOW_ONLY_DEEP_DOZE, 9'h04c, 9'h1fc);
        reach(omc_pkg::SLOW_ONLY_RUN, 9'h1ec, 9'h1ff);
        apb(1'b1, omc_pkg::SYSCTL_B_OFS, 32'he0);
        reach(omc_pkg::DUAL_SLOW_RUN, 9'h1fc, 9'h1ff);
        apb(1'b1, omc_pkg::SYSCTL_B_OFS, 32'hc0);
        reach(omc_pkg::DUAL_FAST_RUN, 9'h1fa, 9'h1ff);
        apb(1'b1, omc_pkg::SYSCTL_B_OFS, 32'hc8);
        reach(omc_pkg::DUAL_FAST_DOZE, 9'h07a, 9'h1ff);
        pulse(8'h01, 1'b0);
        reach(omc_pkg::DUAL_FAST_RUN, 9'h1fa, 9'h1ff);
        pulse(8'h00, 1'b1);
    endtask

    // Each of the three release inputs ends one stop in turn.
    task t_stop;
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, omc_pkg::SYSCTL_A_OFS, 32'h80);
            repeat (40) @(posedge ref_clk_in);
            reach(omc_pkg::STOP_HOLD, 9'h000, 9'h1f8);
            {volt_detect_release_in, key_wakeup_in,
                stop_pin_release_in} <= 3'b001 << i;
            @(posedge ref_clk_in);
            {volt_detect_release_in, key_wakeup_in,
                stop_pin_release_in} <= 3'b000;
            reach(omc_pkg::DUAL_FAST_RUN, 9'h1fa, 9'h1ff);
        end
    endtask

    initial begin
        repeat (20) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        t_reset;
        t_doze;
        t_deep;
        t_dual;
        t_stop;
        test_done;
    end

    // The whole run needs well under this many cycles.
    initial begin
        repeat (60000) @(posedge ref_clk_in);
        failures++;
        test_done;
    end
endmodule

// ### omc_pkg.sv
package omc_pkg;

    // Register byte offsets on the APB bus.
    localparam logic [7:0] SYSCTL_A_OFS = 8'h00;
    localparam logic [7:0] SYSCTL_B_OFS = 8'h04;
    localparam logic [7:0] TB_CTRL_OFS = 8'h08;
    localparam logic [7:0] IRQ_EN_OFS = 8'h0c;
    localparam logic [7:0] WARMUP_CMP_OFS = 8'h10;
    localparam logic [7:0] STATUS_OFS = 8'h14;

    // Field positions of system_control_reg_a.
    localparam int STOP_REQ_BIT = 7;
    // Field positions of system_control_reg_b.
    localparam int HIGH_OSC_EN_BIT = 7;
    localparam int LOW_OSC_EN_BIT = 6;
    localparam int CLK_SEL_BIT = 5;
    localparam int CORE_HALT_BIT = 3;
    localparam int TG_STOP_BIT = 2;
    // Field positions of time_base_control_reg.
    localparam int TB_EN_BIT = 7;
    localparam int TB_SEL_LSB = 0;
    localparam int TB_SEL_W = 3;
    // Interrupt enable bit of the time base timer.
    localparam int TB_IRQ_EN_IDX = 5;
    // Status register layout.
    localparam int STAT_WARMUP_BIT = 16;

    // Reset values.
    localparam logic HIGH_OSC_EN_RST = 1'b1;
    localparam logic LOW_OSC_EN_RST = 1'b0;
    localparam logic CLK_SEL_RST = 1'b0;
    localparam logic [7:0] WARMUP_CMP_RST = 8'h66;

    // Warm-up counter shape: fourteen stages, the upper eight compared.
    localparam int WARMUP_W = 14;
    localparam int WARMUP_CMP_W = 8;
    localparam int NUM_IRQ = 8;
    localparam int NUM_TB_SRC = 8;
    localparam int STATE_W = 11;

    typedef enum logic [STATE_W-1:0] {
        SINGLE_RUN = 11'h001,
        SINGLE_DOZE = 11'h002,
        SINGLE_DEEP_DOZE = 11'h004,
        DUAL_FAST_RUN = 11'h008,
        DUAL_FAST_DOZE = 11'h010,
        DUAL_SLOW_RUN = 11'h020,
        SLOW_ONLY_RUN = 11'h040,
        SLOW_ONLY_DOZE = 11'h080,
        SLOW_ONLY_DEEP_DOZE = 11'h100,
        STOP_HOLD = 11'h200,
        STOP_WARMUP = 11'h400
    } omc_mode_type;

endpackage

// ### omc_properties.sv
`timescale 1ns/1ns
// Gate and bus answer checks of the mode controller.
module omc_checker (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic apb_psel_in,
    input wire logic apb_penable_in,
    input wire logic apb_pready_out,
    input wire logic [omc_pkg::NUM_IRQ-1:0] irq_latch_in,
    input wire logic cpu_clk_en_out,
    input wire logic wdt_clk_en_out,
    input wire logic tb_clk_en_out,
    input wire logic periph_clk_en_out,
    input wire logic high_osc_run_out,
    input wire logic low_osc_run_out,
    input wire logic sys_clk_from_low_out,
    input wire logic prescaler_run_out,
    input wire logic low_osc_pins_gpio_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    // Core stopped while peripherals run: one of the doze states.
    sequence doze_s;
        !cpu_clk_en_out && periph_clk_en_out;
    endsequence
    sequence release_s;
        sys_rst_in ##1 !sys_rst_in;
    endsequence
    reset_values_a: assert property (disable iff (1'b0)
        sys_rst_in |=> !cpu_clk_en_out && !periph_clk_en_out
        && high_osc_run_out && low_osc_pins_gpio_out && !apb_pready_out)
        else $error("reset values wrong");
    release_run_a: assert property (disable iff (1'b0)
        release_s |=> cpu_clk_en_out && periph_clk_en_out
        && prescaler_run_out && !sys_clk_from_low_out)
        else $error("release did not enter single run");
    cpu_wdt_pair_a: assert property (
        cpu_clk_en_out == wdt_clk_en_out)
        else $error("cpu and watchdog gates differ");
    pins_owned_a: assert property (
        low_osc_run_out |-> !low_osc_pins_gpio_out)
        else $error("oscillator pins left as ports");
    doze_hold_a: assert property (
        doze_s ##0 (irq_latch_in == '0) |=> !cpu_clk_en_out)
        else $error("doze left without interrupt");
    slow_prescale_a: assert property (
        sys_clk_from_low_out && periph_clk_en_out |-> !prescaler_run_out)
        else $error("prescaler runs in slow mode");
    stop_quiet_a: assert property (
        !high_osc_run_out && !low_osc_run_out |->
        !cpu_clk_en_out && !periph_clk_en_out && !tb_clk_en_out)
        else $error("clocks run with oscillators stopped");
    bus_answer_a: assert property (
        apb_psel_in && apb_penable_in && !apb_pready_out
        |=> apb_pready_out ##1 !apb_pready_out)
        else $error("bus answer late or long");
endmodule

bind omc_operation_mode_controller omc_checker CHK (.*);
